// File: rtl/spcs_pkg.sv
// Constants for the standby, power-on and configuration sequencer.
// Assumes a 50 MHz clock and a 32-bit AXI4-Lite register bus.
package spcs_pkg;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GATE = 8'h04;
  localparam logic [7:0] OFS_BANK = 8'h08;
  localparam logic [7:0] OFS_CLKEN = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PGUARD = 8'h14;
  // CTRL fields
  localparam int CTRL_MON_EN = 0;
  localparam int CTRL_REF_1V2 = 1;
  localparam int CTRL_CRC_EN = 2;
  localparam int CTRL_WAKE_EN = 3;
  localparam int CTRL_SW_STBY = 4;
  localparam int CTRL_OSC_OFF = 5;
  localparam int CTRL_PLL_OFF = 6;
  localparam int CTRL_REG_PART = 7;
  // GATE fields: what standby switches off
  localparam int GATE_REF = 0;
  localparam int GATE_MON = 1;
  localparam int GATE_OSC = 2;
  localparam int GATE_PLL = 3;
  localparam int GATE_PG = 4;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [4:0] GATE_RESET = 5'h00;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int PLL_LOCK_US = 10;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_US * (CLK_HZ / 1_000_000));
  localparam int SERIAL_PINS = 10;
  localparam int TAP_PINS = 5;
  // Configuration sources
  typedef enum logic [2:0] {
    SRC_NONE = 3'd0, SRC_FLASH = 3'd1, SRC_TAP = 3'd2,
    SRC_SPI_M = 3'd3, SRC_SPI_S = 3'd4, SRC_I2C = 3'd5
  } spcs_src_t;
  // Gray code along power-up, config, CRC, user, standby, wake path
  typedef enum logic [2:0] {
    ST_MONITOR = 3'b000, ST_CONFIG = 3'b001, ST_CRC = 3'b011,
    ST_USER = 3'b010, ST_STBY = 3'b110, ST_WAKE = 3'b111
  } spcs_state_t;
endpackage : spcs_pkg

// File: rtl/spcs_sequencer.sv
// Standby, power-on reset and configuration sequencer with AXI4-Lite registers.
// Assumes supply comparator levels, config port requests and PLL clock levels
// arrive synchronous to aclk.
// Functional notes
// - Standby on input toggle or serial/TAP command
// - Standby keeps configuration and logic alive
// - Selected subsystems gated automatically in standby
// - Reference off also kills monitor, PLL, oscillator
// - Monitor off leaves low-power detector active
// - Oscillator static disable plus standby disable
// - PLL disable; wait for outputs low first
// - Per-bank referenced buffer dynamic switch-off
// - Per primary clock net dynamic enable
// - Input buffer power guard gate
// - Both supplies up then flash download
// - User pins tristate until configuration done
// - Core supply drop triggers reset, remonitor; here a drop is ignored while in ST_CONFIG
// - Reference off uses lower drop threshold
// - Regulated parts monitor external supply too
// - Five configuration sources accepted
// - Selected config port held until cycle ends
// - Test port may take over anytime
// - Optional CRC check entering user mode
// - Ten dual-use serial config pins
// - Four test pins reusable as user pins
// - Serial core standby/wake only when enabled
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
module spcs_sequencer #(
  parameter int NBANK = 4,
  parameter int NCLK = 8,
  parameter int NPLL = 2,
  parameter int NPG = 8,
  parameter int LOCK_CYC = spcs_pkg::PLL_LOCK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stby_req,
  input wire logic serial_stby_cmd,
  input wire logic serial_wake_cmd,
  input wire logic tap_stby_cmd,
  input wire logic tap_wake_cmd,
  input wire logic core_above_up,
  input wire logic bank_above_up,
  input wire logic ext_above_up,
  input wire logic core_below_accurate,
  input wire logic core_below_lowpower,
  input wire logic ext_below_drop,
  input wire logic [NPLL-1:0] pll_out_high,
  input wire logic [2:0] cfg_port_req,
  input wire logic tap_take,
  input wire logic cfg_done,
  input wire logic crc_ok,
  output logic config_start,
  output spcs_pkg::spcs_src_t cfg_src,
  output logic device_reset,
  output logic pins_tristate,
  output logic [spcs_pkg::SERIAL_PINS-1:0] serial_pin_gp,
  output logic [spcs_pkg::TAP_PINS-2:0] tap_pin_gp,
  output logic ref_on,
  output logic mon_on,
  output logic lp_mon_on,
  output logic osc_on,
  output logic [NPLL-1:0] pll_on,
  output logic [NPLL-1:0] pll_clk_en,
  output logic [NBANK-1:0] bank_ref_on,
  output logic [NCLK-1:0] clk_net_en,
  output logic [NPG-1:0] pguard_on,
  output logic core_stby,
  output logic core_wake
);
  import spcs_pkg::*;

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  spcs_state_t st_reg, st_next;
  spcs_src_t src_reg, src_next;
  logic [7:0] ctrl_reg;
  logic [4:0] gate_reg;
  logic [NBANK-1:0] bank_reg;
  logic [NCLK-1:0] clken_reg;
  logic [NPG-1:0] pg_reg;
  logic stby_req_reg, crc_fail_reg, drop_seen_reg;
  logic [15:0] lock_cnt_reg;
  logic aw_hold, w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_hold && w_hold && !s_axi_bvalid;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire [7:0] ra = s_axi_araddr[7:0];
  wire wr_hit = (aw_addr == OFS_CTRL) || (aw_addr == OFS_GATE) || (aw_addr == OFS_BANK) ||
                (aw_addr == OFS_CLKEN) || (aw_addr == OFS_PGUARD) || (aw_addr == OFS_STATUS);
  wire rd_hit = (ra == OFS_CTRL) || (ra == OFS_GATE) || (ra == OFS_BANK) ||
                (ra == OFS_CLKEN) || (ra == OFS_PGUARD) || (ra == OFS_STATUS);
  wire [31:0] status_w = {22'h0, crc_fail_reg, drop_seen_reg, src_reg, st_reg,
                          stby_req_reg, pins_tristate};
  wire [31:0] rd_mux =
    (ra == OFS_CTRL) ? {24'h0, ctrl_reg} :
    (ra == OFS_GATE) ? {27'h0, gate_reg} :
    (ra == OFS_BANK) ? 32'(bank_reg) :
    (ra == OFS_CLKEN) ? 32'(clken_reg) :
    (ra == OFS_PGUARD) ? 32'(pg_reg) :
    (ra == OFS_STATUS) ? status_w : 32'h0;
  wire [31:0] ctrl_m = merge({24'h0, ctrl_reg}, w_data, w_strb);
  wire [31:0] gate_m = merge({27'h0, gate_reg}, w_data, w_strb);
  wire [31:0] bank_m = merge(32'(bank_reg), w_data, w_strb);
  wire [31:0] clk_m = merge(32'(clken_reg), w_data, w_strb);
  wire [31:0] pg_m = merge(32'(pg_reg), w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold && !aw_fire;
      s_axi_wready <= !w_hold && !w_fire;
      if (aw_fire) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
      end
      if (w_fire) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Register writes; STATUS bits 8 and 9 clear on write-one
  wire wr_ctrl = wr_go && aw_addr == OFS_CTRL;
  wire clr_drop = wr_go && aw_addr == OFS_STATUS && w_strb[1] && w_data[8];
  wire clr_crc = wr_go && aw_addr == OFS_STATUS && w_strb[1] && w_data[9];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RESET;
      gate_reg <= GATE_RESET;
      bank_reg <= '1;
      clken_reg <= '1;
      pg_reg <= '1;
    end else if (wr_go) begin
      if (wr_ctrl) ctrl_reg <= ctrl_m[7:0];
      if (aw_addr == OFS_GATE) gate_reg <= gate_m[4:0];
      if (aw_addr == OFS_BANK) bank_reg <= bank_m[NBANK-1:0];
      if (aw_addr == OFS_CLKEN) clken_reg <= clk_m[NCLK-1:0];
      if (aw_addr == OFS_PGUARD) pg_reg <= pg_m[NPG-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Standby requests
  // ------------------------------------------------------------------
  wire sw_stby = ctrl_reg[CTRL_SW_STBY];
  wire toggle = stby_req ^ stby_req_reg;
  wire enter_cmd = toggle || serial_stby_cmd || tap_stby_cmd;
  wire leave_cmd = toggle || serial_wake_cmd || tap_wake_cmd;
  // Reference only gateable on low-voltage core parts
  wire ref_gate = gate_reg[GATE_REF] && ctrl_reg[CTRL_REF_1V2];
  wire in_stby = (st_reg == ST_STBY);
  wire ref_off = in_stby && ref_gate;
  wire mon_off = ref_off || (in_stby && gate_reg[GATE_MON]);
  wire pll_gate = ctrl_reg[CTRL_PLL_OFF] || (in_stby && (gate_reg[GATE_PLL] || ref_gate));
  wire pll_quiet = ~|pll_out_high;
  wire [NPLL-1:0] pll_off_now = pll_gate ? pll_out_high ^ pll_out_high : '1;

  // Drop selection follows which monitor is running
  wire core_drop = mon_off ? core_below_lowpower : core_below_accurate;
  wire ext_drop = ctrl_reg[CTRL_REG_PART] && ext_below_drop;
  wire mon_drop = ctrl_reg[CTRL_MON_EN] && (core_drop || ext_drop);
  wire supplies_up = core_above_up && bank_above_up &&
                     (!ctrl_reg[CTRL_REG_PART] || ext_above_up);
  wire lock_done = (lock_cnt_reg >= 16'(LOCK_CYC));

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    src_next = src_reg;
    unique case (st_reg)
      ST_MONITOR: if (supplies_up) begin
        st_next = ST_CONFIG;
        src_next = SRC_FLASH;
      end
      ST_CONFIG: if (cfg_done) begin
        st_next = ctrl_reg[CTRL_CRC_EN] ? ST_CRC : ST_USER;
      end
      ST_CRC: st_next = ST_USER;
      ST_USER: if (enter_cmd || sw_stby) begin
        st_next = ST_STBY;
      end
      ST_STBY: if (leave_cmd || (!sw_stby && ctrl_reg[CTRL_WAKE_EN] && core_wake)) begin
        st_next = ST_WAKE;
      end
      ST_WAKE: if (lock_done) begin
        st_next = ST_USER;
      end
      default: st_next = ST_MONITOR;
    endcase
    // Port arbitration: TAP preempts, others latched until cycle ends
    if (st_reg == ST_CONFIG || st_reg == ST_MONITOR) begin
      if (tap_take) begin
        src_next = SRC_TAP;
      end else if (st_reg == ST_CONFIG && src_reg == SRC_FLASH &&
                   cfg_port_req != 3'(SRC_NONE) && cfg_port_req <= 3'(SRC_I2C)) begin
        src_next = spcs_src_t'(cfg_port_req);
      end
    end else if (tap_take) begin
      st_next = ST_CONFIG;
      src_next = SRC_TAP;
    end
    if (st_reg == ST_CONFIG && cfg_done) begin
      src_next = SRC_NONE;
    end
    if (mon_drop && st_reg != ST_MONITOR && st_reg != ST_CONFIG) begin
      st_next = ST_MONITOR;
      src_next = SRC_NONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_MONITOR;
      src_reg <= SRC_NONE;
      stby_req_reg <= 1'b0;
      lock_cnt_reg <= 16'h0;
      drop_seen_reg <= 1'b0;
      crc_fail_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      src_reg <= src_next;
      stby_req_reg <= stby_req;
      lock_cnt_reg <= (st_reg == ST_WAKE) ? lock_cnt_reg + 16'h1 : 16'h0;
      // Set wins over a simultaneous clear
      if (mon_drop && st_next == ST_MONITOR) drop_seen_reg <= 1'b1;
      else if (clr_drop) drop_seen_reg <= 1'b0;
      if (st_reg == ST_CRC && !crc_ok) crc_fail_reg <= 1'b1;
      else if (clr_crc) crc_fail_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Outputs, all registered
  // ------------------------------------------------------------------
  wire cfg_phase = (st_next == ST_MONITOR) || (st_next == ST_CONFIG);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_start <= 1'b0;
      cfg_src <= SRC_NONE;
      device_reset <= 1'b1;
      pins_tristate <= 1'b1;
      serial_pin_gp <= '0;
      tap_pin_gp <= '0;
      ref_on <= 1'b1;
      mon_on <= 1'b1;
      lp_mon_on <= 1'b1;
      osc_on <= 1'b1;
      pll_on <= '0;
      pll_clk_en <= '0;
      bank_ref_on <= '0;
      clk_net_en <= '0;
      pguard_on <= '0;
      core_stby <= 1'b0;
      core_wake <= 1'b0;
    end else begin
      config_start <= (st_reg == ST_MONITOR) && (st_next == ST_CONFIG);
      cfg_src <= src_next;
      device_reset <= (st_next == ST_MONITOR);
      pins_tristate <= cfg_phase || st_next == ST_CRC;
      // Dual-use pins become user pins once no longer configuring
      serial_pin_gp <= cfg_phase ? '0 : '1;
      tap_pin_gp <= cfg_phase ? '0 : '1;
      ref_on <= !ref_off;
      mon_on <= !mon_off;
      lp_mon_on <= 1'b1;
      osc_on <= !ctrl_reg[CTRL_OSC_OFF] && !(in_stby && (gate_reg[GATE_OSC] || ref_gate));
      // PLL off only after its outputs have gone low
      for (int i = 0; i < NPLL; i++) begin
        if (!pll_gate) pll_on[i] <= 1'b1;
        else if (!pll_out_high[i] || !pll_on[i]) pll_on[i] <= 1'b0;
      end
      pll_clk_en <= (st_reg == ST_USER || (st_reg == ST_STBY && !pll_gate)) ?
                    pll_on & pll_off_now : '0;
      bank_ref_on <= (cfg_phase || ref_off) ? '0 : bank_reg;
      clk_net_en <= cfg_phase ? '0 : clken_reg;
      pguard_on <= (in_stby && gate_reg[GATE_PG]) ? '0 : pg_reg;
      core_stby <= ctrl_reg[CTRL_WAKE_EN] && sw_stby;
      core_wake <= ctrl_reg[CTRL_WAKE_EN] && !sw_stby && in_stby && pll_quiet;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_user_stby;
    st_reg == ST_USER ##1 st_reg == ST_STBY;
  endsequence
  a_pins_held_config: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_CONFIG |-> pins_tristate) else $error("pins released in config");
  a_stby_entry_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_USER && serial_stby_cmd && !mon_drop && !tap_take |=> st_reg == ST_STBY)
    else $error("standby not entered");
  a_ref_gates_all: assert property (@(posedge aclk) disable iff (!aresetn)
    s_user_stby ##0 ref_gate |=> !ref_on && !mon_on && !osc_on)
    else $error("reference gating incomplete");
  // The low-power detector must still trip while the main monitor sleeps
  a_lp_mon_alive: assert property (@(posedge aclk) disable iff (!aresetn)
    mon_off && in_stby && ctrl_reg[CTRL_MON_EN] && core_below_lowpower |=>
    lp_mon_on && st_reg == ST_MONITOR) else $error("no monitor left");
  a_pll_waits_low: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pll_on[0]) |-> !$past(pll_out_high[0])) else $error("pll off while high");
  a_drop_resets: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_USER && mon_drop |=> st_reg == ST_MONITOR ##0 device_reset)
    else $error("drop missed");
  a_src_held: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_CONFIG && src_reg != SRC_FLASH && src_reg != SRC_NONE && !tap_take
    && !cfg_done && !mon_drop |=> $stable(src_reg)) else $error("config source changed");
  a_wake_lock_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    st_reg == ST_WAKE |=> pll_clk_en == '0) else $error("pll clock before lock");
  a_start_after_up: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(config_start) |-> $past(supplies_up)) else $error("config before supplies");
endmodule : spcs_sequencer

// File: tb/spcs_partner.sv
// Model of the user logic or outside master that asks for standby and wake.
// Assumes the bench pulses go for one aclk cycle with kind and lag settled.
module spcs_partner (
  input wire logic aclk,
  input wire logic go,
  input wire logic [2:0] kind,
  input wire logic [3:0] lag,
  output logic stby_req,
  output logic serial_stby_cmd,
  output logic serial_wake_cmd,
  output logic tap_stby_cmd,
  output logic tap_wake_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Kinds: 0 toggle, 1 serial enter, 2 serial leave, 3 tap enter, 4 tap leave
  // ------------------------------------------------------------------
  initial begin
    stby_req = 1'b0;
    {serial_stby_cmd, serial_wake_cmd, tap_stby_cmd, tap_wake_cmd} = 4'h0;
    forever begin
      @(posedge aclk);
      if (go === 1'b1) begin
        // Slow partner: lag cycles pass before it acts
        repeat (lag) @(posedge aclk);
        case (kind)
          3'h0: stby_req <= ~stby_req;
          3'h1: serial_stby_cmd <= 1'b1;
          3'h2: serial_wake_cmd <= 1'b1;
          3'h3: tap_stby_cmd <= 1'b1;
          default: tap_wake_cmd <= 1'b1;
        endcase
        @(posedge aclk);
        {serial_stby_cmd, serial_wake_cmd, tap_stby_cmd, tap_wake_cmd} <= 4'h0;
      end
    end
  end
endmodule : spcs_partner

// File: tb/spcs_sequencer_tb.sv
// Self-checking bench for the standby, power-on and configuration sequencer.
// Assumes the design package is compiled first; AXI answers are checked in order.
module spcs_sequencer_tb;
  import spcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} spcs_exp_t;
  localparam int LOCK = 8;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, lf, ck;
  logic [3:0] s_axi_wstrb, bank_ref_on, lag;
  logic [1:0] s_axi_bresp, s_axi_rresp, pll_out_high, pll_on, pll_clk_en;
  logic stby_req, serial_stby_cmd, serial_wake_cmd, tap_stby_cmd, tap_wake_cmd, go;
  logic core_above_up, bank_above_up, ext_above_up, core_below_accurate;
  logic core_below_lowpower, ext_below_drop, tap_take, cfg_done, crc_ok, config_start;
  logic device_reset, pins_tristate, ref_on, mon_on, lp_mon_on, osc_on, core_stby, core_wake;
  logic [2:0] cfg_port_req, kind;
  logic [9:0] serial_pin_gp;
  logic [3:0] tap_pin_gp;
  logic [7:0] clk_net_en, pguard_on;
  spcs_src_t cfg_src;
  spcs_exp_t rq[$];
  spcs_exp_t e;
  logic [1:0] bq[$];
  int n_fail = 0;
  int tests_run = 0;
  int n_cs = 0;

  spcs_sequencer #(.LOCK_CYC(LOCK)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stby_req, .serial_stby_cmd,
    .serial_wake_cmd, .tap_stby_cmd, .tap_wake_cmd, .core_above_up, .bank_above_up,
    .ext_above_up, .core_below_accurate, .core_below_lowpower, .ext_below_drop,
    .pll_out_high, .cfg_port_req, .tap_take, .cfg_done, .crc_ok, .config_start, .cfg_src,
    .device_reset, .pins_tristate, .serial_pin_gp, .tap_pin_gp, .ref_on, .mon_on,
    .lp_mon_on, .osc_on, .pll_on, .pll_clk_en, .bank_ref_on, .clk_net_en, .pguard_on,
    .core_stby, .core_wake);
  spcs_partner partner (.aclk, .go, .kind, .lag, .stby_req, .serial_stby_cmd,
    .serial_wake_cmd, .tap_stby_cmd, .tap_wake_cmd);

  // ------------------------------------------------------------------
  // Checking and reporting
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report

  // Answers are compared against the oldest note when their handshake completes
  always @(posedge aclk) begin
    if (config_start === 1'b1) n_cs <= n_cs + 1;
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      e = rq.pop_front();
      chk(s_axi_rdata & e.m, e.d & e.m);
      chk({30'h0, s_axi_rresp}, {30'h0, e.r});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    end
  end

  // ------------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(r);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
    rq.push_back('{d, m, r});
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axr

  task automatic stby(input logic [2:0] k, input logic [3:0] l);
    go <= 1'b1;
    kind <= k;
    lag <= l;
    @(posedge aclk);
    go <= 1'b0;
    repeat (l + 3) @(posedge aclk);
  endtask : stby

  task automatic pulse_done;
    cfg_done <= 1'b1;
    @(posedge aclk);
    cfg_done <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse_done

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    final_report();
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hf;
    // No background flash programming here, so no right PLL reset is owed
    {go, kind, lag, pll_out_high, cfg_port_req, ext_below_drop} = 14'h0;
    {core_above_up, bank_above_up, ext_above_up, core_below_accurate} = 4'h0;
    {core_below_lowpower, tap_take, cfg_done, crc_ok} = 4'h0;
    lf = 32'h14;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({device_reset, pins_tristate, ref_on, mon_on, lp_mon_on, osc_on, serial_pin_gp,
         tap_pin_gp}, 20'hfc000);
    axr(OFS_CTRL, {24'h0, CTRL_RESET}, 32'hff, 2'h0);
    axr(OFS_GATE, {27'h0, GATE_RESET}, 32'h1f, 2'h0);
    axr(8'h40, 32'h0, 32'hffffffff, 2'h2);
    axw(8'h40, 32'h1, 2'h2);
    core_above_up <= 1'b1;
    cfg_port_req <= 3'h3;
    repeat (5) @(posedge aclk);
    chk(n_cs, 0);
    {bank_above_up, ext_above_up} <= 2'h3;
    repeat (5) @(posedge aclk);
    chk(n_cs, 1);
    cfg_port_req <= 3'h4;
    repeat (3) @(posedge aclk);
    chk({29'h0, cfg_src}, {29'h0, SRC_SPI_M});
    chk({31'h0, pins_tristate}, 32'h1);
    pulse_done();
    axr(OFS_STATUS, 32'h08, 32'h1d, 2'h0);
    chk({18'h0, serial_pin_gp, tap_pin_gp}, 32'h3fff);
    lf = lfsr(lf);
    ck = lf;
    axw(OFS_CLKEN, ck, 2'h0);
    lf = lfsr(lf);
    axw(OFS_BANK, lf, 2'h0);
    chk({24'h0, clk_net_en}, {24'h0, ck[7:0]});
    chk({28'h0, bank_ref_on}, {28'h0, lf[3:0]});
    axw(OFS_PGUARD, 32'hff, 2'h0);
    axw(OFS_GATE, 32'h1f, 2'h0);
    for (int i = 0; i < 3; i++) begin
      axw(OFS_CTRL, (i == 0) ? 32'h01 : 32'h03, 2'h0);
      pll_out_high <= 2'h3;
      stby((i == 0) ? 3'h0 : (i == 1) ? 3'h1 : 3'h3, 4'(i * 3));
      repeat (3) @(posedge aclk);
      chk({30'h0, pll_on}, 32'h3);
      pll_out_high <= 2'h0;
      repeat (4) @(posedge aclk);
      chk({30'h0, pll_on}, 32'h0);
      chk({ref_on, mon_on, lp_mon_on, osc_on}, {(i == 0), 3'h2});
      chk({device_reset, pins_tristate, pguard_on}, 10'h0);
      chk({24'h0, clk_net_en}, {24'h0, ck[7:0]});
      axr(OFS_STATUS, 32'h18, 32'h1c, 2'h0);
      stby((i == 0) ? 3'h0 : (i == 1) ? 3'h2 : 3'h4, 4'h0);
      chk({30'h0, pll_clk_en}, 32'h0);
      repeat (LOCK + 6) @(posedge aclk);
      chk({pll_on, pll_clk_en, ref_on, mon_on, osc_on, pguard_on}, 15'h7fff);
    end
    stby(3'h1, 4'h0);
    core_below_accurate <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({31'h0, device_reset}, 32'h0);
    // A real drop also takes the core below its power-up trip
    {core_below_lowpower, core_above_up} <= 2'h2;
    repeat (4) @(posedge aclk);
    chk({31'h0, device_reset}, 32'h1);
    {core_below_accurate, core_below_lowpower, core_above_up} <= 3'h1;
    repeat (6) @(posedge aclk);
    chk(n_cs, 2);
    axr(OFS_STATUS, 32'h100, 32'h100, 2'h0);
    axw(OFS_STATUS, 32'h100, 2'h0);
    axr(OFS_STATUS, 32'h0, 32'h100, 2'h0);
    tap_take <= 1'b1;
    repeat (3) @(posedge aclk);
    chk({29'h0, cfg_src}, {29'h0, SRC_TAP});
    tap_take <= 1'b0;
    axw(OFS_CTRL, 32'h05, 2'h0);
    pulse_done();
    axr(OFS_STATUS, 32'h208, 32'h21c, 2'h0);
    crc_ok <= 1'b1;
    repeat (4) @(posedge aclk);
    axr(OFS_STATUS, 32'h08, 32'h1d, 2'h0);
    axw(OFS_CTRL, 32'h19, 2'h0);
    chk({30'h0, core_stby, core_wake}, 32'h2);
    axw(OFS_CTRL, 32'h09, 2'h0);
    chk({30'h0, core_stby, core_wake}, 32'h1);
    repeat (LOCK + 6) @(posedge aclk);
    axr(OFS_STATUS, 32'h08, 32'h1c, 2'h0);
    axw(OFS_CTRL, 32'h81, 2'h0);
    {ext_below_drop, ext_above_up} <= 2'h2;
    repeat (4) @(posedge aclk);
    chk({31'h0, device_reset}, 32'h1);
    final_report();
  end
endmodule : spcs_sequencer_tb
